// file: sog_addr_gen.sv
// segment and offset generator for memory, register, immediate operands
//
// Overview of operation
// - memory address is a 2-bit segment choice plus 16-bit offset.
// - instruction prefetch always uses the code segment register.
// - stack pushes/pops and frame-base references use the stack segment.
// - other data references default to the data segment register.
// - string destinations use the extra segment register.
// - an override prefix replaces the implicit segment for the operand.
// - offset is the 16-bit sum of present elements, carry dropped.
// - 8-bit displacement is sign-extended to 16 bits before adding.
// - displacement is an 8- or 16-bit immediate from the instruction.
// - base element is general base or frame base register only.
// - index element is source or destination index register only.
// - direct mode offset equals the displacement alone.
// - register indirect offset is exactly one index or base register.
// - based mode offset is displacement plus one base register.
// - indexed mode offset is displacement plus one index register.
// - based indexed offset is base plus index, no displacement.
// - based indexed with displacement sums base, index, displacement.
// - register mode takes a general register, no memory address.
// - immediate mode takes instruction bytes, no memory address.
`include "sog_defines.svh"

module sog_addr_gen (
    // clock and reset
    input  logic                   mclk,
    input  logic                   rst_n,
    // decoded request
    input  logic                   reqValid,
    output logic                   reqReady,
    input  sog_pkg::sog_kind_t     accKind,
    input  sog_pkg::sog_mode_t     addrMode,
    input  sog_pkg::sog_base_t     baseSel,
    input  sog_pkg::sog_index_t    indexSel,
    input  sog_pkg::sog_indir_t    indirSel,
    input  logic                   dispWide,
    input  logic [`SOG_WORD_W-1:0] dispIn,
    input  logic                   ovrValid,
    input  sog_pkg::sog_seg_t      ovrSeg,
    // register file and instruction stream values
    input  logic [`SOG_WORD_W-1:0] generalBase,
    input  logic [`SOG_WORD_W-1:0] frameBase,
    input  logic [`SOG_WORD_W-1:0] sourceIndex,
    input  logic [`SOG_WORD_W-1:0] destIndex,
    input  logic [`SOG_WORD_W-1:0] stackPtr,
    input  logic [`SOG_WORD_W-1:0] instPtr,
    input  logic [`SOG_WORD_W-1:0] regOperand,
    input  logic [`SOG_WORD_W-1:0] immOperand,
    input  logic                   opWide,
    // result toward the bus unit
    output logic                   outValid,
    output sog_pkg::sog_seg_t      outSeg,
    output logic [`SOG_WORD_W-1:0] outOffset,
    output logic                   outIsMem,
    output logic [`SOG_WORD_W-1:0] outOperand
);

    // true when the frame base register acts as base of the operand
    function automatic logic framed(
        input sog_pkg::sog_mode_t  m,
        input sog_pkg::sog_base_t  b,
        input sog_pkg::sog_indir_t r
    );
        logic f;
        f = 1'b0;
        case (m)
            sog_pkg::MODE_BASED,
            sog_pkg::MODE_BI,
            sog_pkg::MODE_BID: f = (b == sog_pkg::BASE_FRAME);
            sog_pkg::MODE_INDIR: f = (r == sog_pkg::IND_FRAME);
            default: f = 1'b0;
        endcase
        return f;
    endfunction

    // implicit segment before any override
    function automatic sog_pkg::sog_seg_t implicitSeg(
        input sog_pkg::sog_kind_t k,
        input logic               frm
    );
        sog_pkg::sog_seg_t s;
        s = sog_pkg::SEG_DATA;
        case (k)
            sog_pkg::KIND_PREFETCH: s = sog_pkg::SEG_CODE;
            sog_pkg::KIND_STACK:    s = sog_pkg::SEG_STACK;
            sog_pkg::KIND_STR_DST:  s = sog_pkg::SEG_EXTRA;
            sog_pkg::KIND_OPERAND:
                s = frm ? sog_pkg::SEG_STACK
                        : sog_pkg::SEG_DATA;
            default: s = sog_pkg::SEG_DATA;
        endcase
        return s;
    endfunction

    function automatic logic memMode(input sog_pkg::sog_mode_t m);
        return !(m == sog_pkg::MODE_REG || m == sog_pkg::MODE_IMM);
    endfunction

    sog_pkg::sog_state_t    state_r;
    sog_pkg::sog_state_t    state_nxt;
    logic [`SOG_WORD_W-1:0] dispExt;
    logic [`SOG_WORD_W-1:0] baseVal;
    logic [`SOG_WORD_W-1:0] indexVal;
    logic [`SOG_WORD_W-1:0] indirVal;
    logic                   frameUsed;
    sog_pkg::sog_seg_t      segPick;

    sog_sum_if sumBus ();

    sog_offset_adder u_adder (
        .bus (sumBus)
    );

    // no back-pressure: one request per cycle
    assign reqReady = 1'b1;

    always_comb begin
        dispExt = dispWide ? dispIn
                : {{`SOG_BYTE_W{dispIn[`SOG_SIGN_BIT]}},
                   dispIn[`SOG_BYTE_W-1:0]};
        baseVal = (baseSel == sog_pkg::BASE_FRAME) ? frameBase
                : generalBase;
        indexVal = (indexSel == sog_pkg::IDX_DEST) ? destIndex
                 : sourceIndex;
        case (indirSel)
            sog_pkg::IND_SOURCE:  indirVal = sourceIndex;
            sog_pkg::IND_DEST:    indirVal = destIndex;
            sog_pkg::IND_GENERAL: indirVal = generalBase;
            sog_pkg::IND_FRAME:   indirVal = frameBase;
            default:              indirVal = sourceIndex;
        endcase
    end

    // element steering into the adder
    always_comb begin
        sumBus.disp     = `SOG_ZERO_WORD;
        sumBus.base     = baseVal;
        sumBus.index    = indexVal;
        sumBus.useBase  = 1'b0;
        sumBus.useIndex = 1'b0;
        case (addrMode)
            sog_pkg::MODE_DIRECT: begin
                sumBus.disp = dispExt;
            end
            sog_pkg::MODE_INDIR: begin
                sumBus.base    = indirVal;
                sumBus.useBase = 1'b1;
            end
            sog_pkg::MODE_BASED: begin
                sumBus.disp    = dispExt;
                sumBus.useBase = 1'b1;
            end
            sog_pkg::MODE_INDEXED: begin
                sumBus.disp     = dispExt;
                sumBus.useIndex = 1'b1;
            end
            sog_pkg::MODE_BI: begin
                sumBus.useBase  = 1'b1;
                sumBus.useIndex = 1'b1;
            end
            sog_pkg::MODE_BID: begin
                sumBus.disp     = dispExt;
                sumBus.useBase  = 1'b1;
                sumBus.useIndex = 1'b1;
            end
            default: begin
                sumBus.disp = `SOG_ZERO_WORD;
            end
        endcase
    end

    // segment choice with override
    always_comb begin
        frameUsed = framed(addrMode, baseSel, indirSel);
        segPick   = implicitSeg(accKind, frameUsed);
        if (accKind == sog_pkg::KIND_OPERAND && ovrValid) begin
            segPick = ovrSeg;
        end
    end

    // next state
    always_comb begin
        state_nxt       = state_r;
        state_nxt.valid = reqValid;
        if (reqValid) begin
            state_nxt.seg = segPick;
            case (accKind)
                sog_pkg::KIND_PREFETCH: begin
                    state_nxt.offset = instPtr;
                    state_nxt.isMem  = 1'b1;
                end
                sog_pkg::KIND_STACK: begin
                    state_nxt.offset = stackPtr;
                    state_nxt.isMem  = 1'b1;
                end
                sog_pkg::KIND_STR_DST: begin
                    state_nxt.offset = destIndex;
                    state_nxt.isMem  = 1'b1;
                end
                default: begin
                    state_nxt.isMem = memMode(addrMode);
                    state_nxt.offset = memMode(addrMode)
                        ? sumBus.sum
                        : `SOG_ZERO_WORD;
                    if (addrMode == sog_pkg::MODE_REG) begin
                        state_nxt.operand = opWide ? regOperand
                            : {`SOG_ZERO_BYTE,
                               regOperand[`SOG_BYTE_W-1:0]};
                    end else if (addrMode == sog_pkg::MODE_IMM) begin
                        state_nxt.operand = opWide ? immOperand
                            : {`SOG_ZERO_BYTE,
                               immOperand[`SOG_BYTE_W-1:0]};
                    end
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state_r.valid   <= 1'b0;
            state_r.seg     <= sog_pkg::SEG_CODE;
            state_r.offset  <= `SOG_OFFSET_RST;
            state_r.isMem   <= 1'b0;
            state_r.operand <= `SOG_OPERAND_RST;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign outValid   = state_r.valid;
    assign outSeg     = state_r.seg;
    assign outOffset  = state_r.offset;
    assign outIsMem   = state_r.isMem;
    assign outOperand = state_r.operand;

    // checking helpers
    logic [`SOG_WORD_W:0]   bidWide;
    logic [`SOG_WORD_W-1:0] signDisp;
    logic                   opReq;
    assign bidWide  = {1'b0, dispExt} + {1'b0, baseVal}
                    + {1'b0, indexVal};
    assign signDisp = {{`SOG_BYTE_W{dispIn[`SOG_SIGN_BIT]}},
                       dispIn[`SOG_BYTE_W-1:0]};
    assign opReq    = reqValid && accKind == sog_pkg::KIND_OPERAND;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    mem_pair_form_a: assert property (
        opReq && memMode(addrMode) |=> outValid && outIsMem
            && ($past(ovrValid) || outSeg inside
                {sog_pkg::SEG_STACK, sog_pkg::SEG_DATA})
    ) else $error("memory operand missing segment:offset pair");

    prefetch_code_seg_a: assert property (
        reqValid && accKind == sog_pkg::KIND_PREFETCH
        |=> outSeg == sog_pkg::SEG_CODE && outOffset == $past(instPtr)
    ) else $error("prefetch not in code segment");

    stack_seg_a: assert property (
        (reqValid && accKind == sog_pkg::KIND_STACK)
        || (opReq && !ovrValid && framed(addrMode, baseSel, indirSel))
        |=> outSeg == sog_pkg::SEG_STACK
    ) else $error("stack reference not in stack segment");

    data_default_a: assert property (
        opReq && !ovrValid && memMode(addrMode)
        && !framed(addrMode, baseSel, indirSel)
        |=> outSeg == sog_pkg::SEG_DATA
    ) else $error("data reference not in data segment");

    string_dest_a: assert property (
        reqValid && accKind == sog_pkg::KIND_STR_DST
        |=> outSeg == sog_pkg::SEG_EXTRA && outOffset == $past(destIndex)
    ) else $error("string destination not in extra segment");

    override_seg_a: assert property (
        opReq && ovrValid |=> outSeg == $past(ovrSeg)
    ) else $error("override segment not applied");

    offset_wrap_a: assert property (
        opReq && addrMode == sog_pkg::MODE_BID
        |=> outOffset == $past(bidWide[`SOG_WORD_W-1:0])
    ) else $error("full offset sum wrong");

    disp_sign_a: assert property (
        opReq && addrMode == sog_pkg::MODE_DIRECT && !dispWide
        |=> outOffset == $past(signDisp)
    ) else $error("short displacement not sign extended");

    direct_offset_a: assert property (
        opReq && addrMode == sog_pkg::MODE_DIRECT && dispWide
        |=> outOffset == $past(dispIn)
    ) else $error("direct offset differs from displacement");

    indirect_reg_a: assert property (
        opReq && addrMode == sog_pkg::MODE_INDIR
        && indirSel == sog_pkg::IND_GENERAL
        |=> outOffset == $past(generalBase)
    ) else $error("indirect offset not the chosen register");

    based_frame_a: assert property (
        opReq && addrMode == sog_pkg::MODE_BASED
        && baseSel == sog_pkg::BASE_FRAME && dispWide
        |=> outOffset == 16'($past(frameBase) + $past(dispIn))
    ) else $error("based offset wrong");

    indexed_dest_a: assert property (
        opReq && addrMode == sog_pkg::MODE_INDEXED
        && indexSel == sog_pkg::IDX_DEST && dispWide
        |=> outOffset == 16'($past(destIndex) + $past(dispIn))
    ) else $error("indexed offset wrong");

    based_index_a: assert property (
        opReq && addrMode == sog_pkg::MODE_BI
        && baseSel == sog_pkg::BASE_GENERAL
        && indexSel == sog_pkg::IDX_SOURCE
        |=> outOffset == 16'($past(generalBase) + $past(sourceIndex))
    ) else $error("based indexed offset wrong");

    register_op_a: assert property (
        opReq && addrMode == sog_pkg::MODE_REG && opWide
        |=> !outIsMem && outOperand == $past(regOperand)
    ) else $error("register operand wrong or memory flagged");

    immediate_op_a: assert property (
        opReq && addrMode == sog_pkg::MODE_IMM && !opWide
        |=> !outIsMem
            && outOperand == {`SOG_ZERO_BYTE,
                              $past(immOperand[`SOG_BYTE_W-1:0])}
    ) else $error("immediate operand wrong or memory flagged");

    result_timing_a: assert property (
        reqValid ##1 !reqValid |-> outValid ##1 !outValid
    ) else $error("result strobe not one cycle after request");

    cover_override_c: cover property (
        opReq && ovrValid ##1 outValid
    );
    cover_bid_wrap_c: cover property (
        opReq && addrMode == sog_pkg::MODE_BID && bidWide[`SOG_WORD_W]
    );
    cover_frame_c: cover property (
        opReq && framed(addrMode, baseSel, indirSel) ##1 outValid
    );
    cover_b2b_c: cover property (
        reqValid ##1 reqValid ##1 reqValid
    );

endmodule

// file: sog_defines.svh
// address generator constants: widths, reset values, segment size
`ifndef SOG_DEFINES_SVH
`define SOG_DEFINES_SVH

`define SOG_WORD_W      16
`define SOG_BYTE_W      8
`define SOG_SIGN_BIT    7
`define SOG_SEG_BYTES   17'h10000
`define SOG_OFFSET_RST  16'h0000
`define SOG_OPERAND_RST 16'h0000
`define SOG_ZERO_BYTE   8'h00
`define SOG_ZERO_WORD   16'h0000

`endif

// file: sog_pkg.sv
// address generator types: modes, access kinds, selectors, state
`include "sog_defines.svh"

package sog_pkg;

    typedef enum logic [2:0] {
        MODE_REG, MODE_IMM, MODE_DIRECT, MODE_INDIR,
        MODE_BASED, MODE_INDEXED, MODE_BI, MODE_BID
    } sog_mode_t;

    typedef enum logic [1:0] {
        KIND_OPERAND, KIND_PREFETCH, KIND_STACK, KIND_STR_DST
    } sog_kind_t;

    typedef enum logic [1:0] {
        SEG_EXTRA, SEG_CODE, SEG_STACK, SEG_DATA
    } sog_seg_t;

    typedef enum logic {BASE_GENERAL, BASE_FRAME} sog_base_t;
    typedef enum logic {IDX_SOURCE, IDX_DEST} sog_index_t;

    typedef enum logic [1:0] {
        IND_SOURCE, IND_DEST, IND_GENERAL, IND_FRAME
    } sog_indir_t;

    typedef struct packed {
        logic                   valid;
        sog_seg_t               seg;
        logic [`SOG_WORD_W-1:0] offset;
        logic                   isMem;
        logic [`SOG_WORD_W-1:0] operand;
    } sog_state_t;

endpackage

// file: sog_sum_if.sv
// offset adder operand bundle between controller and adder
`include "sog_defines.svh"

interface sog_sum_if;
    logic [`SOG_WORD_W-1:0] disp;
    logic [`SOG_WORD_W-1:0] base;
    logic [`SOG_WORD_W-1:0] index;
    logic                   useBase;
    logic                   useIndex;
    logic [`SOG_WORD_W-1:0] sum;

    modport ctrl (
        output disp, base, index, useBase, useIndex,
        input  sum
    );
    modport adder (
        input  disp, base, index, useBase, useIndex,
        output sum
    );
endinterface

// file: sog_offset_adder.sv
// three-element modulo 2^16 offset adder
`include "sog_defines.svh"

module sog_offset_adder (
    sog_sum_if.adder bus
);
    logic [`SOG_WORD_W:0] wideSum;
    logic [`SOG_WORD_W:0] baseTerm;
    logic [`SOG_WORD_W:0] indexTerm;

    always_comb begin
        baseTerm  = bus.useBase  ? {1'b0, bus.base}  : '0;
        indexTerm = bus.useIndex ? {1'b0, bus.index} : '0;
        wideSum   = {1'b0, bus.disp} + baseTerm + indexTerm;
        // carry out of the top bit is dropped
        bus.sum   = wideSum[`SOG_WORD_W-1:0];
    end
endmodule

// file: sog_regfile_model.sv
// register file and instruction stream model feeding the address generator
module sog_regfile_model (
    // clock
    input  wire logic        mclk,
    // write port driven by the bench
    input  wire logic        wrEn,
    input  wire logic [2:0]  wrSel,
    input  wire logic [15:0] wrData,
    // register values toward the generator
    output logic      [15:0] generalBase,
    output logic      [15:0] frameBase,
    output logic      [15:0] sourceIndex,
    output logic      [15:0] destIndex,
    output logic      [15:0] stackPtr,
    output logic      [15:0] instPtr,
    output logic      [15:0] regOperand,
    output logic      [15:0] immOperand
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [15:0] regFile [8];

    initial begin
        foreach (regFile[i]) begin
            regFile[i] = 16'h0000;
        end
    end

    // one register rewritten per edge, like a write-back port
    always @(posedge mclk) begin
        if (wrEn) begin
            regFile[wrSel] <= wrData;
        end
    end

    assign generalBase = regFile[0];
    assign frameBase   = regFile[1];
    assign sourceIndex = regFile[2];
    assign destIndex   = regFile[3];
    assign stackPtr    = regFile[4];
    assign instPtr     = regFile[5];
    assign regOperand  = regFile[6];
    assign immOperand  = regFile[7];
endmodule

// file: segment_offset_address_gen_tb_top.sv
// self-checking bench for the segment and offset generator
`include "sog_defines.svh"

module segment_offset_address_gen_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic reqValid = 1'b0;
    logic reqReady;
    sog_pkg::sog_kind_t accKind = sog_pkg::KIND_OPERAND;
    sog_pkg::sog_mode_t addrMode = sog_pkg::MODE_DIRECT;
    sog_pkg::sog_base_t baseSel = sog_pkg::BASE_GENERAL;
    sog_pkg::sog_index_t indexSel = sog_pkg::IDX_SOURCE;
    sog_pkg::sog_indir_t indirSel = sog_pkg::IND_SOURCE;
    sog_pkg::sog_seg_t ovrSeg = sog_pkg::SEG_DATA;
    sog_pkg::sog_seg_t outSeg;
    logic dispWide = 1'b0;
    logic ovrValid = 1'b0;
    logic opWide = 1'b0;
    logic [15:0] dispIn = 16'h0000;
    logic [15:0] generalBase, frameBase, sourceIndex, destIndex;
    logic [15:0] stackPtr, instPtr, regOperand, immOperand;
    logic outValid, outIsMem;
    logic [15:0] outOffset, outOperand;
    logic wrEn = 1'b0;
    logic [2:0] wrSel = 3'h0;
    logic [15:0] wrData = 16'h0000;
    logic [31:0] rngState = 32'hBA61D7DF;
    int badCount = 0;
    int cmpCount = 0;
    logic started = 1'b0;
    logic eValid, eMem, segKnown;
    logic [1:0] eSeg;
    logic [15:0] eOff, eOpd;

    always #20 mclk = ~mclk;

    sog_regfile_model partner (
        .mclk(mclk), .wrEn(wrEn), .wrSel(wrSel), .wrData(wrData),
        .generalBase(generalBase), .frameBase(frameBase),
        .sourceIndex(sourceIndex), .destIndex(destIndex),
        .stackPtr(stackPtr), .instPtr(instPtr),
        .regOperand(regOperand), .immOperand(immOperand)
    );

    sog_addr_gen uut (
        .mclk(mclk), .rst_n(rst_n), .reqValid(reqValid),
        .reqReady(reqReady), .accKind(accKind), .addrMode(addrMode),
        .baseSel(baseSel), .indexSel(indexSel), .indirSel(indirSel),
        .dispWide(dispWide), .dispIn(dispIn), .ovrValid(ovrValid),
        .ovrSeg(ovrSeg), .generalBase(generalBase), .frameBase(frameBase),
        .sourceIndex(sourceIndex), .destIndex(destIndex),
        .stackPtr(stackPtr), .instPtr(instPtr), .regOperand(regOperand),
        .immOperand(immOperand), .opWide(opWide), .outValid(outValid),
        .outSeg(outSeg), .outOffset(outOffset), .outIsMem(outIsMem),
        .outOperand(outOperand)
    );

    function automatic logic [31:0] xs();
        logic [31:0] s;
        s = rngState;
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        rngState = s;
        return s;
    endfunction

    // works out the result of the request now on the inputs
    function automatic void predict();
        logic [15:0] d, b, x, ind;
        logic frm;
        d = dispWide ? dispIn : {{8{dispIn[7]}}, dispIn[7:0]};
        b = (baseSel == sog_pkg::BASE_FRAME) ? frameBase : generalBase;
        x = (indexSel == sog_pkg::IDX_DEST) ? destIndex : sourceIndex;
        case (indirSel)
            sog_pkg::IND_SOURCE:  ind = sourceIndex;
            sog_pkg::IND_DEST:    ind = destIndex;
            sog_pkg::IND_GENERAL: ind = generalBase;
            default:              ind = frameBase;
        endcase
        frm = (addrMode == sog_pkg::MODE_INDIR) ?
              (indirSel == sog_pkg::IND_FRAME) :
              (baseSel == sog_pkg::BASE_FRAME);
        eValid = 1'b1;
        eMem = 1'b1;
        segKnown = 1'b1;
        case (accKind)
            sog_pkg::KIND_PREFETCH: begin
                eSeg = 2'(sog_pkg::SEG_CODE);
                eOff = instPtr;
            end
            sog_pkg::KIND_STACK: begin
                eSeg = 2'(sog_pkg::SEG_STACK);
                eOff = stackPtr;
            end
            sog_pkg::KIND_STR_DST: begin
                eSeg = 2'(sog_pkg::SEG_EXTRA);
                eOff = destIndex;
            end
            default: begin
                case (addrMode)
                    sog_pkg::MODE_DIRECT:  eOff = d;
                    sog_pkg::MODE_INDIR:   eOff = ind;
                    sog_pkg::MODE_BASED:   eOff = d + b;
                    sog_pkg::MODE_INDEXED: eOff = d + x;
                    sog_pkg::MODE_BI:      eOff = b + x;
                    sog_pkg::MODE_BID:     eOff = b + x + d;
                    default:               eOff = 16'h0000;
                endcase
                if (addrMode inside {sog_pkg::MODE_INDIR, sog_pkg::MODE_BASED,
                                     sog_pkg::MODE_BI, sog_pkg::MODE_BID}
                    && frm) begin
                    eSeg = 2'(sog_pkg::SEG_STACK);
                end else begin
                    eSeg = 2'(sog_pkg::SEG_DATA);
                end
                if (ovrValid) begin
                    eSeg = 2'(ovrSeg);
                end
                if (addrMode == sog_pkg::MODE_REG) begin
                    eOpd = opWide ? regOperand : {8'h00, regOperand[7:0]};
                end
                if (addrMode == sog_pkg::MODE_IMM) begin
                    eOpd = opWide ? immOperand : {8'h00, immOperand[7:0]};
                end
                if (addrMode inside {sog_pkg::MODE_REG,
                                     sog_pkg::MODE_IMM}) begin
                    eMem = 1'b0;
                    segKnown = 1'b0;
                end
            end
        endcase
    endfunction

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmpCount++;
        if (got !== exp) begin
            badCount++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // outputs settle by the falling edge; compare, then predict the next
    always @(negedge mclk) begin
        if (started) begin
            chk({15'h0000, reqReady}, 16'h0001);
            chk({15'h0000, outValid}, {15'h0000, eValid});
            chk(outOffset, eOff);
            chk({15'h0000, outIsMem}, {15'h0000, eMem});
            chk(outOperand, eOpd);
            if (segKnown) begin
                chk(16'(outSeg), 16'(eSeg));
            end
        end
        started = 1'b1;
        if (!rst_n) begin
            eValid = 1'b0;
            eSeg = 2'(sog_pkg::SEG_CODE);
            eOff = 16'h0000;
            eMem = 1'b0;
            eOpd = 16'h0000;
            segKnown = 1'b1;
        end else if (reqValid) begin
            predict();
        end else begin
            eValid = 1'b0;
        end
    end

    task automatic send(input logic [1:0] k, input logic [2:0] m,
                        input logic forceV, input logic rstv);
        logic [31:0] r;
        logic [31:0] r2;
        r = xs();
        r2 = xs();
        @(posedge mclk);
        rst_n <= rstv;
        reqValid <= forceV | r[0] | r[1];
        accKind <= sog_pkg::sog_kind_t'(k);
        addrMode <= sog_pkg::sog_mode_t'(m);
        baseSel <= sog_pkg::sog_base_t'(r[2]);
        indexSel <= sog_pkg::sog_index_t'(r[3]);
        indirSel <= sog_pkg::sog_indir_t'(r[5:4]);
        dispWide <= r[6];
        dispIn <= r2[15:0];
        ovrValid <= r[8];
        ovrSeg <= sog_pkg::sog_seg_t'(r[10:9]);
        opWide <= r[11];
        wrEn <= 1'b1;
        wrSel <= r[14:12];
        wrData <= r[15] ? {16{r[16]}} : r2[31:16];
    endtask

    task automatic reportAndStop();
        if (badCount == 0 && cmpCount > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        logic [31:0] r;
        repeat (9) @(posedge mclk);
        // every kind and mode back to back, twice
        for (int p = 0; p < 2; p++) begin
            for (int i = 0; i < 32; i++) begin
                send(2'(i >> 3), 3'(i), 1'b1, 1'b1);
            end
        end
        for (int i = 0; i < 3000; i++) begin
            r = xs();
            send(r[1:0], r[4:2], 1'b0, !(i >= 1500 && i < 1502));
        end
        @(posedge mclk);
        reqValid <= 1'b0;
        repeat (3) @(posedge mclk);
        reportAndStop();
    end

    initial begin
        #(40ns * 10000);
        badCount++;
        reportAndStop();
    end
endmodule
